/* File: core/cbm_consts.svh */
/*
  Constants for the charger boost mode control block: register offsets, field positions,
  reset values and timing counts. Assumes a 100 MHz core clock.
*/
`ifndef CBM_CONSTS_SVH
`define CBM_CONSTS_SVH

`define CBM_CLK_MHZ 100
// Register indices
`define CBM_REG_STATUS 4'h0
`define CBM_REG_CONTROL 4'h1
`define CBM_REG_MODE 4'h2
// Control register fields
`define CBM_CTL_BOOST_SEL 0
`define CBM_CTL_HIZ_REQ 1
`define CBM_CTL_CHG_INHIBIT 2
`define CBM_CTL_OTG_POL 3
`define CBM_CTL_OTG_PIN_EN 4
`define CBM_CTL_WDOG_KICK 7
`define CBM_CTL_RESET 8'h00
// Fault codes
`define CBM_FLT_NONE 3'h0
`define CBM_FLT_BUS_OV 3'h1
`define CBM_FLT_STARTUP 3'h2
`define CBM_FLT_BAT_UV 3'h3
`define CBM_FLT_THERMAL 3'h5
`define CBM_FLT_TIMER 3'h6
// Times in their own units, cycle counts derived from the clock rate
`define CBM_LIN_TIMEOUT_US 560
`define CBM_SS_HALF_US 128
`define CBM_SS_FULL_US 384
`define CBM_ILIM_SUSTAIN_US 50
`define CBM_RETRY_FIRST_US 5200
`define CBM_RETRY_NEXT_US 5000
`define CBM_STROBE_US 128
`define CBM_LIN_CYC (`CBM_LIN_TIMEOUT_US * `CBM_CLK_MHZ)
`define CBM_SS_HALF_CYC (`CBM_SS_HALF_US * `CBM_CLK_MHZ)
`define CBM_SS_FULL_CYC (`CBM_SS_FULL_US * `CBM_CLK_MHZ)
`define CBM_ILIM_CYC (`CBM_ILIM_SUSTAIN_US * `CBM_CLK_MHZ)
`define CBM_RETRY_FIRST_CYC (`CBM_RETRY_FIRST_US * `CBM_CLK_MHZ)
`define CBM_RETRY_NEXT_CYC (`CBM_RETRY_NEXT_US * `CBM_CLK_MHZ)
`define CBM_STROBE_CYC (`CBM_STROBE_US * `CBM_CLK_MHZ)
// 32 s and 15 min at 100 MHz
`define CBM_T32_CYC 64'd3200000000
`define CBM_T15_CYC 64'd90000000000

`endif

/* File: core/cbm_ctrl.sv */
/*
  Charger mode control and boost startup sequencer: register port, timers, mode select,
  boost enable, sequencer with timeouts, pulse skip, fault handling and OTG retry.
  Assumes comparator and pin inputs are asynchronous; register port is on clk_i.
*/
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "cbm_consts.svh"

// Overview of operation
// - Charge only when pin, inhibit, hiz clear
// - Disable pin freezes 32-second timer count
// - Disable pin rise resets 15-minute timer
// - Mode: boost running, else hiz, else fault, else boost/charge
// - Boost off clears boost select bit
// - Boost only allowed in 32-second mode
// - OTG pin active when equal to polarity
// - Active OTG pin boosts despite hiz
// - Register boost needs hiz clear
// - 32 s expiry in boost: reset, fault 110
// - Status read or power-on clears fault
// - Above reference at off-time end: pulse skip
// - Sequencer goes linear, soft start, run
// - Shut down boost with charge off holds path switches off
// - Linear startup, fault after 560 us
// - Soft start half limit, then full
// - Full limit after 128 us, fault +384 us
// - Boost fault: strobe, clear select, hiz, code
// - OTG retry after 5.2 ms, then 5 ms
// - Fault codes per cause
module cbm_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic disable_pin_i,
  input wire logic otg_pin_i,
  input wire cbm_pkg::cbm_cmp_t cmp_i,
  input wire logic fifteen_min_mode_i,
  output logic charge_en_o,
  output cbm_pkg::cbm_opmode_t opmode_o,
  output cbm_pkg::cbm_pwr_t pwr_o,
  output logic status_strobe_o
);
  import cbm_pkg::*;

  logic [9:0] raw_in;
  logic [9:0] sync_in;
  cbm_cmp_t cmp;
  logic dis_pin, otg_pin;
  logic [7:0] ctrl_ff;
  logic [2:0] fault_ff;
  logic fault_active_ff;
  logic dis_pin_d_ff;
  logic [63:0] t32_ff, t15_ff;
  logic t32_expire;
  cbm_seq_t seq_ff;
  logic [19:0] seq_cnt_ff;
  logic ilim_full_ff;
  logic [15:0] ilim_cnt_ff;
  logic boost_req, boost_req_d_ff, otg_active, boost_fault;
  logic [2:0] boost_code;
  logic retry_wait_ff, retry_first_ff, retry_go;
  logic [19:0] retry_cnt_ff;
  logic [15:0] strobe_cnt_ff;
  logic pskip_ff;

  function automatic logic [19:0] c20(input int v);
    c20 = 20'(v);
  endfunction

  assign raw_in = {disable_pin_i, otg_pin_i, cmp_i};
  cbm_sync #(.WIDTH(10)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );
  assign cmp = sync_in[7:0];
  assign otg_pin = sync_in[8];
  assign dis_pin = sync_in[9];

  assign otg_active = (otg_pin == ctrl_ff[`CBM_CTL_OTG_POL]) && ctrl_ff[`CBM_CTL_OTG_PIN_EN];
  // boost enable needs 32-second mode; pin or register path
  assign boost_req = !fifteen_min_mode_i && !retry_wait_ff
    && (otg_active || (ctrl_ff[`CBM_CTL_BOOST_SEL] && !ctrl_ff[`CBM_CTL_HIZ_REQ]));
  assign t32_expire = (t32_ff >= `CBM_T32_CYC - 64'd1) && !dis_pin;

  always_comb begin
    boost_fault = 1'b0;
    boost_code = `CBM_FLT_NONE;
    if (seq_ff != CBM_SQ_OFF) begin
      if (cmp.bus_ov) begin
        boost_fault = 1'b1;
        boost_code = `CBM_FLT_BUS_OV;
      end else if (cmp.thermal) begin
        boost_fault = 1'b1;
        boost_code = `CBM_FLT_THERMAL;
      end else if (!cmp.bat_above_uv) begin
        boost_fault = 1'b1;
        boost_code = `CBM_FLT_BAT_UV;
      end else if ((seq_ff == CBM_SQ_LIN && !cmp.mid_rail_node_ok && seq_cnt_ff >= c20(`CBM_LIN_CYC - 1))
        || (seq_ff == CBM_SQ_SS && !cmp.out_at_95
        && seq_cnt_ff >= c20(`CBM_SS_HALF_CYC + `CBM_SS_FULL_CYC - 1))
        || (seq_ff == CBM_SQ_RUN && ilim_cnt_ff >= 16'(`CBM_ILIM_CYC))) begin
        boost_fault = 1'b1;
        boost_code = `CBM_FLT_STARTUP;
      end
    end
  end

  // Control register; kick bit self-clears
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= `CBM_CTL_RESET;
    end else if (ce_i) begin
      if (wr_i && addr_i == `CBM_REG_CONTROL) begin
        ctrl_ff <= wdata_i;
      end else begin
        ctrl_ff[`CBM_CTL_WDOG_KICK] <= 1'b0;
      end
      if (seq_ff != CBM_SQ_OFF && t32_expire) begin
        ctrl_ff <= `CBM_CTL_RESET;
      end else if (boost_fault || (seq_ff != CBM_SQ_OFF && !boost_req)) begin
        ctrl_ff[`CBM_CTL_BOOST_SEL] <= 1'b0;
      end
    end
  end

  // Fault latch; set wins over read clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fault_ff <= `CBM_FLT_NONE;
      fault_active_ff <= 1'b0;
    end else if (ce_i) begin
      if (seq_ff != CBM_SQ_OFF && t32_expire) begin
        fault_ff <= `CBM_FLT_TIMER;
        fault_active_ff <= 1'b1;
      end else if (boost_fault) begin
        fault_ff <= boost_code;
        fault_active_ff <= 1'b1;
      end else if (rd_i && addr_i == `CBM_REG_STATUS) begin
        fault_ff <= `CBM_FLT_NONE;
        fault_active_ff <= 1'b0;
      end
    end
  end

  // disable pin holds the 32 s count
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      t32_ff <= 64'd0;
    end else if (ce_i) begin
      if (ctrl_ff[`CBM_CTL_WDOG_KICK] || t32_expire) begin
        t32_ff <= 64'd0;
      end else if (!dis_pin) begin
        t32_ff <= t32_ff + 64'd1;
      end
    end
  end

  // disable pin rising clears 15 min timer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      t15_ff <= 64'd0;
      dis_pin_d_ff <= 1'b0;
    end else if (ce_i) begin
      dis_pin_d_ff <= dis_pin;
      if (fifteen_min_mode_i && dis_pin && !dis_pin_d_ff) begin
        t15_ff <= 64'd0;
      end else if (fifteen_min_mode_i && charge_en_o && t15_ff < `CBM_T15_CYC) begin
        t15_ff <= t15_ff + 64'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seq_ff <= CBM_SQ_OFF;
      seq_cnt_ff <= 20'h0;
      ilim_full_ff <= 1'b0;
      boost_req_d_ff <= 1'b0;
    end else if (ce_i) begin
      boost_req_d_ff <= boost_req;
      seq_cnt_ff <= seq_cnt_ff + 20'h1;
      if (boost_fault || !boost_req || t32_expire) begin
        seq_ff <= CBM_SQ_OFF;
        ilim_full_ff <= 1'b0;
      end else begin
        case (seq_ff)
          CBM_SQ_OFF: begin
            // enter linear on enable rising edge
            if ((boost_req && !boost_req_d_ff || retry_go) && cmp.bat_above_uv) begin
              seq_ff <= CBM_SQ_LIN;
              seq_cnt_ff <= 20'h0;
            end
          end
          CBM_SQ_LIN: begin
            if (cmp.mid_rail_node_ok) begin
              seq_ff <= CBM_SQ_SS;
              seq_cnt_ff <= 20'h0;
              ilim_full_ff <= 1'b0;
            end
          end
          CBM_SQ_SS: begin
            if (seq_cnt_ff >= c20(`CBM_SS_HALF_CYC - 1)) begin
              ilim_full_ff <= 1'b1;
            end
            if (cmp.out_at_95 && cmp.bat_above_uv) begin
              seq_ff <= CBM_SQ_RUN;
              ilim_full_ff <= 1'b1;
            end
          end
          CBM_SQ_RUN: ;
          default: seq_ff <= CBM_SQ_OFF;
        endcase
      end
    end
  end

  // Sustained current limit in run state
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ilim_cnt_ff <= 16'h0;
    end else if (ce_i) begin
      ilim_cnt_ff <= (seq_ff == CBM_SQ_RUN && cmp.ilim_hit) ? ilim_cnt_ff + 16'h1 : 16'h0;
    end
  end

  assign retry_go = retry_wait_ff && retry_cnt_ff == 20'h0;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      retry_wait_ff <= 1'b0;
      retry_first_ff <= 1'b1;
      retry_cnt_ff <= 20'h0;
    end else if (ce_i) begin
      if (!otg_active) begin
        retry_wait_ff <= 1'b0;
        retry_first_ff <= 1'b1;
      end else if (boost_fault) begin
        retry_wait_ff <= 1'b1;
        retry_cnt_ff <= retry_first_ff ? c20(`CBM_RETRY_FIRST_CYC - 1) : c20(`CBM_RETRY_NEXT_CYC - 1);
        retry_first_ff <= 1'b0;
      end else if (retry_wait_ff) begin
        if (retry_cnt_ff == 20'h0) begin
          retry_wait_ff <= 1'b0;
        end else begin
          retry_cnt_ff <= retry_cnt_ff - 20'h1;
        end
      end else if (seq_ff == CBM_SQ_RUN) begin
        retry_first_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pskip_ff <= 1'b0;
    end else if (ce_i) begin
      if (seq_ff != CBM_SQ_RUN || !cmp.out_above_ref) begin
        pskip_ff <= 1'b0;
      end else if (cmp.toff_end) begin
        pskip_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      strobe_cnt_ff <= 16'h0;
      status_strobe_o <= 1'b0;
    end else if (ce_i) begin
      if (boost_fault || (seq_ff != CBM_SQ_OFF && t32_expire)) begin
        strobe_cnt_ff <= 16'(`CBM_STROBE_CYC - 1);
        status_strobe_o <= 1'b1;
      end else if (strobe_cnt_ff != 16'h0) begin
        strobe_cnt_ff <= strobe_cnt_ff - 16'h1;
      end else begin
        status_strobe_o <= 1'b0;
      end
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      charge_en_o <= 1'b0;
      opmode_o <= CBM_OP_HIZ;
      pwr_o <= '0;
    end else if (ce_i) begin
      charge_en_o <= !dis_pin && !ctrl_ff[`CBM_CTL_CHG_INHIBIT] && !ctrl_ff[`CBM_CTL_HIZ_REQ]
        && !fault_active_ff && seq_ff == CBM_SQ_OFF;
      if (seq_ff != CBM_SQ_OFF) begin
        opmode_o <= CBM_OP_BOOST;
      end else if (ctrl_ff[`CBM_CTL_HIZ_REQ]) begin
        opmode_o <= CBM_OP_HIZ;
      end else if (fault_active_ff) begin
        opmode_o <= CBM_OP_CFG;
      end else begin
        // select bit cannot show boost under the 15-minute timer
        opmode_o <= (ctrl_ff[`CBM_CTL_BOOST_SEL] && !fifteen_min_mode_i) ? CBM_OP_BOOST : CBM_OP_CHARGE;
      end
      pwr_o.precharge_on <= seq_ff == CBM_SQ_LIN;
      pwr_o.switching_on <= (seq_ff == CBM_SQ_SS || seq_ff == CBM_SQ_RUN) && !pskip_ff;
      pwr_o.ilim_full <= ilim_full_ff;
      pwr_o.loop_closed <= seq_ff == CBM_SQ_RUN;
      pwr_o.pulse_skip <= pskip_ff;
      pwr_o.long_on_time <= pskip_ff;
      // path switches off when boost is down and charging is off
      pwr_o.path_off <= seq_ff == CBM_SQ_OFF && !charge_en_o;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      case (addr_i)
        `CBM_REG_STATUS: rdata_o <= {5'h00, fault_ff};
        `CBM_REG_CONTROL: rdata_o <= ctrl_ff;
        `CBM_REG_MODE: rdata_o <= {2'h0, pskip_ff, ilim_full_ff, seq_ff, opmode_o};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  a_seq_lin_to_ss: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && seq_ff == CBM_SQ_LIN && cmp.mid_rail_node_ok && !boost_fault && boost_req && !t32_expire
    |=> seq_ff == CBM_SQ_SS && !ilim_full_ff) else $error("lin to ss failed");
  a_charge_block: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && dis_pin |=> !charge_en_o) else $error("charge with disable pin");
  a_fault_strobe: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && boost_fault |=> status_strobe_o && fault_active_ff) else $error("no strobe on fault");
  a_timer_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && seq_ff != CBM_SQ_OFF && t32_expire |=> fault_ff == `CBM_FLT_TIMER && ctrl_ff == 8'h00)
    else $error("timer fault wrong");
  a_read_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && rd_i && addr_i == `CBM_REG_STATUS && !boost_fault && !(seq_ff != CBM_SQ_OFF && t32_expire)
    |=> fault_ff == 3'h0) else $error("read did not clear fault");
  a_t32_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && dis_pin && !ctrl_ff[`CBM_CTL_WDOG_KICK] |=> t32_ff == $past(t32_ff)) else $error("t32 moved");
  a_no_boost_15: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && fifteen_min_mode_i && seq_ff == CBM_SQ_OFF |=> seq_ff == CBM_SQ_OFF) else $error("boost in 15 min mode");
  a_t15_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && fifteen_min_mode_i && dis_pin && !dis_pin_d_ff |=> t15_ff == 64'd0) else $error("t15 not cleared");
  a_pskip_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !cmp.out_above_ref |=> !pskip_ff) else $error("pulse skip stuck");
  a_sel_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && boost_fault |=> !ctrl_ff[`CBM_CTL_BOOST_SEL]) else $error("select not cleared");
  c_run: cover property (@(posedge clk_i) seq_ff == CBM_SQ_RUN);
  c_retry: cover property (@(posedge clk_i) retry_go);
  c_pskip: cover property (@(posedge clk_i) pskip_ff);
endmodule // cbm_ctrl

/* File: core/cbm_pkg.sv */
/*
  Types for the charger boost mode control block.
  Assumes cbm_consts.svh supplies the numeric constants.
*/
package cbm_pkg;

  typedef enum logic [1:0] {
    CBM_OP_CHARGE = 2'h0,
    CBM_OP_CFG = 2'h1,
    CBM_OP_BOOST = 2'h3,
    CBM_OP_HIZ = 2'h2
  } cbm_opmode_t;

  // Gray along off -> lin -> ss -> run
  typedef enum logic [1:0] {
    CBM_SQ_OFF = 2'h0,
    CBM_SQ_LIN = 2'h1,
    CBM_SQ_SS = 2'h3,
    CBM_SQ_RUN = 2'h2
  } cbm_seq_t;

  typedef struct packed {
    logic mid_rail_node_ok;
    logic out_at_95;
    logic bat_above_uv;
    logic out_above_ref;
    logic ilim_hit;
    logic bus_ov;
    logic thermal;
    logic toff_end;
  } cbm_cmp_t;

  typedef struct packed {
    logic precharge_on;
    logic switching_on;
    logic ilim_full;
    logic loop_closed;
    logic pulse_skip;
    logic long_on_time;
    logic path_off;
  } cbm_pwr_t;

endpackage

/* File: core/cbm_sync.sv */
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs are quasi-static relative to the clock.
*/
`timescale 1ns/100ps
module cbm_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_ff <= '0;
      sync_o <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end
endmodule // cbm_sync

/* File: verification/cbm_host.sv */
/*
  Host processor model: drives the register port of the mode controller.
  Assumes a single clock and strobes taken on the rising edge.
*/
`timescale 1ns/100ps
`include "cbm_consts.svh"
module cbm_host (
  input wire logic clk_i,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask

  // Data follows the address and is sampled one cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  task automatic kick(input logic [7:0] ctl);
    wr_reg(`CBM_REG_CONTROL, ctl | (8'h01 << `CBM_CTL_WDOG_KICK));
  endtask
endmodule // cbm_host

/* File: verification/tb.sv */
/*
  Self-checking bench for the charger mode controller.
  Assumes the host model drives the register port; long timers are not exercised.
*/
`timescale 1ns/100ps
`include "cbm_consts.svh"
module tb;
  import cbm_pkg::*;
  logic clk_i, resetn_i, ce, dis, otg, f15, wr, rd, chg_en, strobe;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, cmp, d;
  cbm_opmode_t opmode;
  cbm_pwr_t pwr;
  integer num_errors = 0;
  integer n_checks = 0;
  int n;

  cbm_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .disable_pin_i(dis), .otg_pin_i(otg), .cmp_i(cmp),
    .fifteen_min_mode_i(f15), .charge_en_o(chg_en), .opmode_o(opmode), .pwr_o(pwr),
    .status_strobe_o(strobe));
  cbm_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h got %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic drive(input logic [7:0] c, input logic p_dis, input logic p_otg, input logic p_f15);
    @(posedge clk_i);
    cmp <= c;
    dis <= p_dis;
    otg <= p_otg;
    f15 <= p_f15;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    host.rd_reg(a, d);
    chk(nm, exp, d);
  endtask

  // Counts cycles until a watched output reaches a level; running out is a failure
  task automatic count_until(input int sel, input int lim, output int k);
    k = 0;
    while (k < lim && !(sel == 0 ? pwr.ilim_full === 1'b1 : sel == 1 ? strobe === 1'b1 : strobe === 1'b0)) begin
      cyc(1);
      k++;
    end
    if (k == lim) begin
      num_errors++;
      $display("Error wait %0d expected done got timeout", sel);
      report_and_stop();
    end
  endtask

  task automatic t_regs();
    rd_chk("ctl_reset", `CBM_REG_CONTROL, `CBM_CTL_RESET);
    rd_chk("status_reset", `CBM_REG_STATUS, 8'h00);
    rd_chk("mode_reset", `CBM_REG_MODE, 8'h00);
    host.wr_reg(4'h5, 8'hff);
    rd_chk("unmapped", 4'h5, 8'h00);
    host.wr_reg(`CBM_REG_STATUS, 8'h07);
    rd_chk("status_ro", `CBM_REG_STATUS, 8'h00);
    // Clock enable low must swallow the write
    @(posedge clk_i) ce <= 1'b0;
    host.wr_reg(`CBM_REG_CONTROL, 8'h04);
    @(posedge clk_i) ce <= 1'b1;
    rd_chk("ce_frozen", `CBM_REG_CONTROL, 8'h00);
  endtask

  task automatic t_charge();
    cyc(6);
    chk("chg_all_clear", 8'h01, chg_en);
    host.wr_reg(`CBM_REG_CONTROL, 8'h04);
    cyc(4);
    chk("chg_inhibit", 8'h00, chg_en);
    host.wr_reg(`CBM_REG_CONTROL, 8'h02);
    cyc(4);
    chk("chg_hiz", 8'h00, chg_en);
    chk("mode_hiz", CBM_OP_HIZ, opmode);
    host.wr_reg(`CBM_REG_CONTROL, 8'h00);
    drive(8'he0, 1'b1, 1'b0, 1'b0);
    cyc(6);
    chk("chg_pin", 8'h00, chg_en);
    drive(8'he0, 1'b0, 1'b0, 1'b0);
    cyc(6);
    chk("chg_back", 8'h01, chg_en);
  endtask

  task automatic t_modes();
    host.wr_reg(`CBM_REG_CONTROL, 8'h01);
    cyc(10);
    chk("mode_boost", CBM_OP_BOOST, opmode);
    host.wr_reg(`CBM_REG_CONTROL, 8'h03);
    cyc(10);
    chk("hiz_over_sel", CBM_OP_HIZ, opmode);
    rd_chk("sel_cleared_hiz", `CBM_REG_CONTROL, 8'h02);
    host.wr_reg(`CBM_REG_CONTROL, 8'h00);
    drive(8'he0, 1'b0, 1'b0, 1'b1);
    host.wr_reg(`CBM_REG_CONTROL, 8'h01);
    cyc(10);
    chk("no_boost_15min", 8'h00, {7'h0, opmode === CBM_OP_BOOST});
    chk("no_switch_15min", 8'h00, pwr.switching_on);
    drive(8'he0, 1'b1, 1'b0, 1'b1);
    cyc(4);
    drive(8'he0, 1'b0, 1'b0, 1'b0);
    host.wr_reg(`CBM_REG_CONTROL, 8'h04);
    cyc(10);
    chk("paths_off", 8'h02, {pwr.path_off, pwr.switching_on});
  endtask

  task automatic t_otg();
    drive(8'he0, 1'b0, 1'b1, 1'b0);
    host.wr_reg(`CBM_REG_CONTROL, 8'h1a);
    cyc(10);
    chk("otg_hi_hiz", 8'h01, pwr.switching_on);
    drive(8'he0, 1'b0, 1'b0, 1'b0);
    cyc(10);
    chk("otg_hi_idle", 8'h00, pwr.switching_on);
    host.wr_reg(`CBM_REG_CONTROL, 8'h12);
    cyc(10);
    chk("otg_lo_active", 8'h01, pwr.switching_on);
    host.wr_reg(`CBM_REG_CONTROL, 8'h00);
    cyc(10);
  endtask

  task automatic t_softstart();
    drive(8'ha0, 1'b0, 1'b0, 1'b0);
    host.wr_reg(`CBM_REG_CONTROL, 8'h01);
    cyc(5);
    chk("ss_half_limit", 8'h00, pwr.ilim_full);
    count_until(0, 14000, n);
    chk("ss_full_at_128us", 8'h01, (n >= 12780 && n <= 12815));
    count_until(1, 40000, n);
    chk("ss_fault_at_384us", 8'h01, (n >= 38390 && n <= 38410));
    count_until(2, 13000, n);
    chk("strobe_width", 8'h01, (n >= 12795 && n <= 12805));
    chk("fault_cfg", CBM_OP_CFG, opmode);
    chk("fault_hiz_stage", 8'h02, {pwr.path_off, pwr.switching_on});
    rd_chk("sel_cleared_fault", `CBM_REG_CONTROL, 8'h00);
    rd_chk("code_startup", `CBM_REG_STATUS, {5'h0, `CBM_FLT_STARTUP});
    rd_chk("code_cleared", `CBM_REG_STATUS, 8'h00);
    cyc(4);
    chk("cfg_left", CBM_OP_CHARGE, opmode);
  endtask

  task automatic t_run();
    logic [7:0] fc [3] = '{8'he4, 8'he2, 8'hc0};
    logic [2:0] code [3] = '{`CBM_FLT_BUS_OV, `CBM_FLT_THERMAL, `CBM_FLT_BAT_UV};
    for (int i = 0; i < 3; i++) begin
      drive(8'he0, 1'b0, 1'b0, 1'b0);
      host.rd_reg(`CBM_REG_STATUS, d);
      host.wr_reg(`CBM_REG_CONTROL, 8'h01);
      cyc(12);
      chk("run_boost", CBM_OP_BOOST, opmode);
      chk("run_loop", 8'h03, {pwr.loop_closed, pwr.ilim_full});
      rd_chk("run_state", `CBM_REG_MODE, 8'h1b);
      host.kick(8'h01);
      rd_chk("kick_clears", `CBM_REG_CONTROL, 8'h01);
      if (i == 0) begin
        drive(8'hf1, 1'b0, 1'b0, 1'b0);
        cyc(8);
        chk("pfm_entry", 8'h03, {pwr.pulse_skip, pwr.long_on_time});
        drive(8'he1, 1'b0, 1'b0, 1'b0);
        cyc(8);
        chk("pfm_exit", 8'h00, pwr.pulse_skip);
      end
      drive(fc[i], 1'b0, 1'b0, 1'b0);
      cyc(8);
      chk("fault_strobe", 8'h01, strobe);
      rd_chk("fault_code", `CBM_REG_STATUS, {5'h0, code[i]});
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    ce = 1'b1;
    cmp = 8'h00;
    dis = 1'b0;
    otg = 1'b0;
    f15 = 1'b0;
    cyc(3);
    chk("rst_outs", 8'h40, {chg_en, opmode, strobe, pwr[3:0]});
    cyc(1);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    drive(8'he0, 1'b0, 1'b0, 1'b0);
    t_regs();
    t_charge();
    t_modes();
    t_otg();
    t_softstart();
    t_run();
    report_and_stop();
  end
endmodule // tb
